// ---- cxs_pkg.sv ----
// constants, types and register map of the instruction execution slice
package cxs_pkg;
  localparam int CLK_NS    = 8;
  localparam int PAUSE_MS  = 40;
  localparam int PAUSE_CYC = PAUSE_MS * 1000000 / CLK_NS;
  localparam int CHARS     = 16;
  // opcodes, octal values written in hex
  localparam logic [5:0] OP_SKEQ  = 6'h04;
  localparam logic [5:0] OP_SKGE  = 6'h05;
  localparam logic [5:0] OP_SREQ  = 6'h06;
  localparam logic [5:0] OP_SRGE  = 6'h07;
  localparam logic [5:0] OP_STEP  = 6'h08;
  localparam logic [5:0] OP_INC   = 6'h0D;
  localparam logic [5:0] OP_LCHA  = 6'h12;
  localparam logic [5:0] OP_LCHQ  = 6'h13;
  localparam logic [5:0] OP_MUL   = 6'h28;
  localparam logic [5:0] OP_FMOVE = 6'h34;
  localparam logic [5:0] OP_DECJ  = 6'h38;
  localparam logic [5:0] OP_MOVE  = 6'h3A;
  localparam logic [5:0] OP_OUTC  = 6'h3D;
  localparam logic [5:0] OP_OUTW  = 6'h3E;
  localparam logic [5:0] OP_EXT   = 6'h3F;
  // variants of the 77 group
  localparam logic [2:0] X_STSN = 3'h0;
  localparam logic [2:0] X_IRSN = 3'h1;
  localparam logic [2:0] X_CLR  = 3'h2;
  localparam logic [2:0] X_ISTA = 3'h3;
  localparam logic [2:0] X_OSTA = 3'h4;
  localparam logic [2:0] X_LJA  = 3'h5;
  localparam logic [2:0] X_WAIT = 3'h6;
  localparam logic [2:0] X_PRIW = 3'h7;
  // variants of 64
  localparam logic [2:0] V_BF   = 3'h0;
  localparam logic [2:0] V_ZF   = 3'h1;
  localparam logic [2:0] V_ZS   = 3'h2;
  localparam logic [2:0] V_ZSDC = 3'h3;
  // processor condition codes
  localparam logic [1:0] BC_ZERO = 2'h0;
  localparam logic [1:0] BC_HI   = 2'h1;
  localparam logic [1:0] BC_LOW  = 2'h2;
  localparam logic [5:0] CH_BLANK = 6'h30;
  localparam logic [5:0] CH_ZERO  = 6'h00;
  // register word indices (byte address = 4 * index)
  localparam logic [5:0] R_INSTR  = 6'h00;
  localparam logic [5:0] R_OPND   = 6'h01;
  localparam logic [5:0] R_ACC    = 6'h02;
  localparam logic [5:0] R_AUX    = 6'h03;
  localparam logic [5:0] R_IDX1   = 6'h04;
  localparam logic [5:0] R_IDX2   = 6'h05;
  localparam logic [5:0] R_IDX3   = 6'h06;
  localparam logic [5:0] R_PC     = 6'h07;
  localparam logic [5:0] R_MEMW   = 6'h08;
  localparam logic [5:0] R_MODE   = 6'h09;
  localparam logic [5:0] R_STATUS = 6'h0A;
  localparam logic [5:0] R_LASTJ  = 6'h0B;
  localparam logic [5:0] R_CHR0   = 6'h10;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [23:0] RST_WORD = 24'h000000;
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_SEARCH, ST_MOVE, ST_PAUSE} cxs_state_e;
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } cxs_axi_req_s;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } cxs_axi_rsp_s;
endpackage : cxs_pkg

// ---- cxs_core.sv ----
// instruction execution slice with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module cxs_core #(
  parameter int unsigned PAUSE_LIMIT_CYC = cxs_pkg::PAUSE_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire cxs_pkg::cxs_axi_req_s axi_req,
  output cxs_pkg::cxs_axi_rsp_s      axi_rsp,
  input  wire logic [11:0]           int_status,
  input  wire logic [11:0]           int_lines,
  input  wire logic [7:0]            chan_busy,
  input  wire logic [7:0]            chan_wide,
  output logic [23:0]                chan_data,
  output logic [2:0]                 chan_sel,
  output logic                       chan_strobe,
  output logic [7:0]                 chan_clear,
  output logic                       rtc_hold
);
  import cxs_pkg::*;

  function automatic logic [23:0] oc_add(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      oc_add = s[23:0] + {23'h000000, s[24]};
    end
  endfunction : oc_add

  function automatic logic [23:0] merge(input logic [23:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    begin
      merge = {st[2] ? d[23:16] : o[23:16], st[1] ? d[15:8] : o[15:8],
               st[0] ? d[7:0] : o[7:0]};
    end
  endfunction : merge

  cxs_state_e  state_reg;
  logic [23:0] instr_reg, opnd_reg, acc_reg, aux_reg, mem_reg, mode_reg;
  logic [14:0] idx_reg [3];
  logic [14:0] pc_reg, lastj_reg;
  logic        skip_reg, reject_reg, sup_reg, dlm_reg;
  logic [3:0]  mv_i_reg;
  logic [22:0] pcnt_reg;
  logic [5:0]  chr_reg [CHARS];
  logic        bvalid_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [23:0] chan_data_reg;
  logic [2:0]  chan_sel_reg;
  logic        chan_strobe_reg;
  logic [7:0]  chan_clear_reg;

  // bus decode
  wire         wr_go   = axi_req.awvalid & axi_req.wvalid & ~bvalid_reg;
  wire         rd_go   = axi_req.arvalid & ~rvalid_reg;
  wire  [5:0]  wa      = axi_req.awaddr[7:2];
  wire  [5:0]  ra      = axi_req.araddr[7:2];
  wire         idle    = (state_reg == ST_IDLE);
  wire         wr_chr  = wr_go & (wa[5:4] == R_CHR0[5:4]);
  wire         wr_map  = wr_chr | (wa <= R_MODE);
  wire         wr_ok   = wr_go & idle & axi_req.wstrb[0];
  wire  [31:0] wd      = axi_req.wdata;
  wire  [3:0]  ws      = axi_req.wstrb;

  // instruction fields
  wire  [5:0]  op      = instr_reg[5:0];
  wire  [2:0]  var3    = instr_reg[8:6];
  wire  [1:0]  bsel    = instr_reg[10:9];
  wire  [14:0] y       = opnd_reg[14:0];
  wire  [14:0] bx      = (bsel == 2'h0) ? 15'h0000 : idx_reg[bsel - 2'h1];
  wire  [14:0] pc_p1   = pc_reg + 15'h0001;
  wire  [14:0] pc_p2   = pc_reg + 15'h0002;
  wire  [1:0]  bp_cond = mode_reg[7:6];
  wire  [11:0] int_msk = mode_reg[19:8];

  // sense and compare terms
  wire         st_hit  = |(int_status & y[11:0]);
  wire         it_hit  = |(int_lines & int_msk);
  wire         bz_hit  = |(chan_busy & y[7:0]);
  wire  [23:0] y_ext   = var3[0] ? {{9{y[14]}}, y} : {9'h000, y};
  wire         eq_skip = var3[0] ? (y == aux_reg[14:0])
                                 : ((bsel != 2'h0) ? (y == bx) : (y == 15'h0000));
  wire         ge_skip = (bsel != 2'h0) ? (bx >= y) : (y == 15'h0000);
  wire         dj_hit  = (var3 == 3'h0) ? (bp_cond == BC_HI)
                       : (var3 == 3'h1) ? (bp_cond == BC_LOW) : (bp_cond == BC_ZERO);

  // search terms
  wire         srch2   = (op == OP_SRGE);
  wire  [14:0] s_idx   = srch2 ? idx_reg[1] : idx_reg[0];
  wire  [14:0] s_nxt   = s_idx - y;
  wire  [23:0] s_msk   = aux_reg & mem_reg;
  wire         s_hit   = srch2 ? (acc_reg >= s_msk) : (acc_reg == s_msk);

  // multiply in sign-magnitude, then complement for a negative product
  wire         m_neg   = acc_reg[23] ^ mem_reg[23];
  wire  [22:0] m_a     = acc_reg[23] ? ~acc_reg[22:0] : acc_reg[22:0];
  wire  [22:0] m_m     = mem_reg[23] ? ~mem_reg[22:0] : mem_reg[22:0];
  wire  [47:0] m_mag   = {2'h0, 46'(m_a) * 46'(m_m)};
  wire  [47:0] m_qa    = m_neg ? ~m_mag : m_mag;

  // character move terms
  wire  [3:0]  mv_src  = opnd_reg[3:0] + mv_i_reg;
  wire  [3:0]  mv_dst  = opnd_reg[7:4] + mv_i_reg;
  wire  [3:0]  mv_slen = opnd_reg[11:8];
  wire  [3:0]  mv_len  = (op == OP_MOVE) ? mv_slen : opnd_reg[15:12];
  wire  [5:0]  src_c   = chr_reg[mv_src];
  wire         dlm_now = (op == OP_FMOVE) && (var3 == V_ZSDC) && (src_c == opnd_reg[21:16]);
  wire         src_end = (mv_i_reg >= mv_slen) | dlm_reg | dlm_now;
  wire  [5:0]  fill_c  = (var3 == V_ZF) ? CH_ZERO : CH_BLANK;
  wire         zs_mode = (op == OP_FMOVE) && ((var3 == V_ZS) || (var3 == V_ZSDC));
  wire         zs_now  = zs_mode & sup_reg & (src_c == CH_ZERO);
  wire  [5:0]  mv_char = src_end ? fill_c : (zs_now ? CH_BLANK : src_c);
  wire         mv_last = (mv_i_reg == mv_len - 4'h1);
  wire         mv_we   = (state_reg == ST_MOVE);
  wire         chr_we  = mv_we | (wr_ok & wr_chr);
  wire  [3:0]  chr_wa  = mv_we ? mv_dst : wa[3:0];
  wire  [5:0]  chr_wd  = mv_we ? mv_char : wd[5:0];

  wire         pz_time = (pcnt_reg >= 23'(PAUSE_LIMIT_CYC));

  // character store: one flip-flop word per entry
  for (genvar g = 0; g < CHARS; g++) begin : g_chr
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        chr_reg[g] <= 6'h00;
      end else if (chr_we && (chr_wa == 4'(g))) begin
        chr_reg[g] <= chr_wd;
      end
    end
  end

  // read mux
  logic [23:0] rd_word;
  logic        rd_bad;
  always_comb begin
    rd_bad  = 1'b0;
    rd_word = 24'h000000;
    if (ra[5:4] == R_CHR0[5:4]) begin
      rd_word = {18'h00000, chr_reg[ra[3:0]]};
    end else begin
      case (ra)
        R_INSTR:  rd_word = instr_reg;
        R_OPND:   rd_word = opnd_reg;
        R_ACC:    rd_word = acc_reg;
        R_AUX:    rd_word = aux_reg;
        R_IDX1:   rd_word = {9'h000, idx_reg[0]};
        R_IDX2:   rd_word = {9'h000, idx_reg[1]};
        R_IDX3:   rd_word = {9'h000, idx_reg[2]};
        R_PC:     rd_word = {9'h000, pc_reg};
        R_MEMW:   rd_word = mem_reg;
        R_MODE:   rd_word = mode_reg;
        R_STATUS: rd_word = {21'h000000, reject_reg, skip_reg, ~idle};
        R_LASTJ:  rd_word = {9'h000, lastj_reg};
        default:  rd_bad  = 1'b1;
      endcase
    end
  end

  // bus slave channels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OK;
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OK;
      rdata_reg  <= 32'h00000000;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_map ? RESP_OK : RESP_ERR;
      end else if (axi_req.bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rd_bad ? RESP_ERR : RESP_OK;
        rdata_reg  <= {8'h00, rd_word};
      end else if (axi_req.rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // execution engine; bus writes to core state land only while idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg       <= ST_IDLE;
      instr_reg       <= RST_WORD;
      opnd_reg        <= RST_WORD;
      acc_reg         <= RST_WORD;
      aux_reg         <= RST_WORD;
      mem_reg         <= RST_WORD;
      mode_reg        <= RST_WORD;
      idx_reg         <= '{15'h0000, 15'h0000, 15'h0000};
      pc_reg          <= 15'h0000;
      lastj_reg       <= 15'h0000;
      skip_reg        <= 1'b0;
      reject_reg      <= 1'b0;
      sup_reg         <= 1'b0;
      dlm_reg         <= 1'b0;
      mv_i_reg        <= 4'h0;
      pcnt_reg        <= 23'h000000;
      chan_data_reg   <= RST_WORD;
      chan_sel_reg    <= 3'h0;
      chan_strobe_reg <= 1'b0;
      chan_clear_reg  <= 8'h00;
    end else begin
      chan_strobe_reg <= 1'b0;
      chan_clear_reg  <= 8'h00;
      case (state_reg)
        ST_IDLE: begin
          if (wr_ok) begin
            case (wa)
              R_INSTR: begin
                instr_reg <= wd[23:0];
                state_reg <= ST_EXEC;
              end
              R_OPND:  opnd_reg  <= merge(opnd_reg, wd, ws);
              R_ACC:   acc_reg   <= merge(acc_reg, wd, ws);
              R_AUX:   aux_reg   <= merge(aux_reg, wd, ws);
              R_IDX1:  idx_reg[0] <= wd[14:0];
              R_IDX2:  idx_reg[1] <= wd[14:0];
              R_IDX3:  idx_reg[2] <= wd[14:0];
              R_PC:    pc_reg    <= wd[14:0];
              R_MEMW:  mem_reg   <= merge(mem_reg, wd, ws);
              R_MODE:  mode_reg  <= merge(mode_reg, wd, ws);
              default: ;
            endcase
          end
        end
        ST_EXEC: begin
          state_reg  <= ST_IDLE;
          skip_reg   <= 1'b0;
          reject_reg <= 1'b0;
          pc_reg     <= pc_p1;
          case (op)
            OP_INC: aux_reg <= oc_add(aux_reg, y_ext);
            OP_SKEQ: begin
              skip_reg <= eq_skip;
              pc_reg   <= eq_skip ? pc_p2 : pc_p1;
            end
            OP_SKGE: begin
              skip_reg <= ge_skip;
              pc_reg   <= ge_skip ? pc_p2 : pc_p1;
            end
            OP_STEP: begin
              if (bsel != 2'h0) begin
                if (bx == y) begin
                  idx_reg[bsel - 2'h1] <= 15'h0000;
                  skip_reg             <= 1'b1;
                  pc_reg               <= pc_p2;
                end else begin
                  idx_reg[bsel - 2'h1] <= var3[0] ? bx + 15'h0001 : bx - 15'h0001;
                end
              end
            end
            OP_SREQ, OP_SRGE: begin
              pc_reg    <= pc_reg;
              state_reg <= ST_SEARCH;
            end
            OP_LCHA: acc_reg <= {18'h00000, chr_reg[y[3:0]]};
            OP_LCHQ: aux_reg <= {18'h00000, chr_reg[y[3:0]]};
            OP_MUL: begin
              acc_reg <= m_qa[23:0];
              aux_reg <= m_qa[47:24];
            end
            OP_MOVE, OP_FMOVE: begin
              mv_i_reg <= 4'h0;
              sup_reg  <= 1'b1;
              dlm_reg  <= 1'b0;
              if (mv_len != 4'h0) begin
                pc_reg    <= pc_reg;
                state_reg <= ST_MOVE;
              end
            end
            OP_DECJ: begin
              if (dj_hit) begin
                pc_reg    <= y;
                lastj_reg <= y;
              end
            end
            OP_OUTC: begin
              chan_data_reg   <= {18'h00000, acc_reg[5:0]};
              chan_sel_reg    <= y[2:0];
              chan_strobe_reg <= 1'b1;
            end
            OP_OUTW: begin
              chan_data_reg   <= chan_wide[y[2:0]] ? acc_reg : {12'h000, acc_reg[11:0]};
              chan_sel_reg    <= y[2:0];
              chan_strobe_reg <= 1'b1;
            end
            OP_EXT: begin
              case (var3)
                X_STSN: begin
                  skip_reg <= ~st_hit;
                  pc_reg   <= st_hit ? pc_p1 : pc_p2;
                end
                X_IRSN: begin
                  skip_reg <= ~it_hit;
                  pc_reg   <= it_hit ? pc_p1 : pc_p2;
                end
                X_CLR: begin
                  chan_clear_reg <= y[8] ? 8'hFF : y[7:0];
                  if (y[11]) begin
                    mv_i_reg <= 4'h0;
                    sup_reg  <= 1'b0;
                    dlm_reg  <= 1'b0;
                  end
                end
                X_ISTA: acc_reg <= {21'h000000, mode_reg[2:0]};
                X_OSTA: acc_reg <= {21'h000000, mode_reg[5:3]};
                X_LJA:  acc_reg <= {9'h000, lastj_reg};
                X_WAIT, X_PRIW: begin
                  pcnt_reg <= 23'h000000;
                  if (bz_hit) begin
                    pc_reg    <= pc_reg;
                    state_reg <= ST_PAUSE;
                  end else begin
                    skip_reg <= 1'b1;
                    pc_reg   <= pc_p2;
                  end
                end
                default: ;
              endcase
            end
            default: ;
          endcase
        end
        ST_SEARCH: begin
          if (srch2) idx_reg[1] <= s_nxt;
          else       idx_reg[0] <= s_nxt;
          if (s_nxt[14]) begin
            state_reg <= ST_IDLE;
            pc_reg    <= pc_p1;
          end else if (s_hit) begin
            state_reg <= ST_IDLE;
            skip_reg  <= 1'b1;
            pc_reg    <= pc_p2;
          end
        end
        ST_MOVE: begin
          mv_i_reg <= mv_i_reg + 4'h1;
          if (dlm_now) dlm_reg <= 1'b1;
          if (!src_end && (src_c != CH_ZERO)) sup_reg <= 1'b0;
          if (mv_last) begin
            state_reg <= ST_IDLE;
            pc_reg    <= pc_p1;
          end
        end
        ST_PAUSE: begin
          pcnt_reg <= pcnt_reg + 23'h000001;
          if (!bz_hit) begin
            state_reg <= ST_IDLE;
            skip_reg  <= 1'b1;
            pc_reg    <= pc_p2;
          end else if (pz_time) begin
            state_reg  <= ST_IDLE;
            reject_reg <= 1'b1;
            pc_reg     <= pc_p1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // real-time clock is frozen only by the priority flavour
  assign rtc_hold = (state_reg == ST_PAUSE) && (var3 == X_PRIW);

  assign axi_rsp.awready = wr_go;
  assign axi_rsp.wready  = wr_go;
  assign axi_rsp.bvalid  = bvalid_reg;
  assign axi_rsp.bresp   = bresp_reg;
  assign axi_rsp.arready = rd_go;
  assign axi_rsp.rvalid  = rvalid_reg;
  assign axi_rsp.rresp   = rresp_reg;
  assign axi_rsp.rdata   = rdata_reg;
  assign chan_data       = chan_data_reg;
  assign chan_sel        = chan_sel_reg;
  assign chan_strobe     = chan_strobe_reg;
  assign chan_clear      = chan_clear_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_zero_skip: assert property ((state_reg == ST_EXEC) && (op == OP_SKEQ) && !var3[0]
    && (bsel == 2'h0) && (y == 15'h0000) |=> pc_reg == $past(pc_reg) + 15'h0002)
    else $error("zero operand did not skip");
  chk_status_sense: assert property ((state_reg == ST_EXEC) && (op == OP_EXT)
    && (var3 == X_STSN) |=> pc_reg == $past(pc_reg) + ($past(st_hit) ? 15'h0001 : 15'h0002))
    else $error("status sense took wrong path");
  chk_int_sense: assert property ((state_reg == ST_EXEC) && (op == OP_EXT)
    && (var3 == X_IRSN) && !it_hit |=> skip_reg && pc_reg == $past(pc_reg) + 15'h0002)
    else $error("interrupt sense failed to skip");
  chk_char_out: assert property ((state_reg == ST_EXEC) && (op == OP_OUTC)
    |=> chan_strobe && (chan_data == {18'h00000, $past(acc_reg[5:0])}) && $stable(acc_reg))
    else $error("character output wrong");
  chk_pause_hold: assert property ((state_reg == ST_PAUSE) && bz_hit && !pz_time
    |=> $stable(pc_reg))
    else $error("program counter moved during pause");
  chk_rtc_freeze: assert property ((state_reg == ST_EXEC) && (op == OP_EXT)
    && (var3 == X_PRIW) && bz_hit |=> rtc_hold)
    else $error("clock not held in priority pause");
  chk_state_read: assert property ((state_reg == ST_EXEC) && (op == OP_EXT)
    && (var3 == X_ISTA) |=> acc_reg == {21'h000000, $past(mode_reg[2:0])})
    else $error("instruction state not in accumulator");
  chk_jump_taken: assert property ((state_reg == ST_EXEC) && (op == OP_DECJ) && dj_hit
    |=> (pc_reg == $past(y)) && (lastj_reg == $past(y)))
    else $error("decision jump missed");
  chk_step_clear: assert property ((state_reg == ST_EXEC) && (op == OP_STEP)
    && (bsel == 2'h2) && (bx == y) |=> idx_reg[1] == 15'h0000 ##1 $stable(idx_reg[1]))
    else $error("index step did not clear");
endmodule : cxs_core

// ---- cxs_periph.sv ----
// peripheral model on the direct output channels
`timescale 1ns/100ps
module cxs_periph (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [23:0] chan_data,
  input  wire logic        chan_strobe,
  input  wire logic [7:0]  chan_clear,
  input  wire logic [7:0]  hold_busy,
  output logic [7:0]       chan_busy,
  output logic [7:0]       chan_wide,
  output logic [23:0]      last_word
);
  logic [1:0] take_cnt;
  assign chan_wide = 8'h0F;
  // busy while a taken word is consumed; bench can stall it
  assign chan_busy = hold_busy | {7'h00, take_cnt != 2'h0};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      take_cnt <= 2'h0;
      last_word <= 24'h000000;
    end else if (chan_strobe) begin
      take_cnt <= 2'h3;
      last_word <= chan_data;
    end else if (chan_clear[0] || take_cnt != 2'h0) begin
      take_cnt <= chan_clear[0] ? 2'h0 : take_cnt - 2'h1;
    end
  end
endmodule : cxs_periph

// ---- testbench.sv ----
// self-checking bench for the execution slice
`timescale 1ns/100ps
module testbench;
  import cxs_pkg::*;
  logic clk, rst_b, strb, rtc, rtc_seen;
  cxs_axi_req_s req;
  cxs_axi_rsp_s rsp;
  logic [11:0] st_l, int_l;
  logic [7:0] busy, wide, clr, hold, clr_seen;
  logic [23:0] cdata, lastw;
  logic [2:0] csel;
  logic [31:0] rd;
  logic [1:0] rr;
  int errors, comparisons, cycles;
  cxs_core #(.PAUSE_LIMIT_CYC(20)) i_dut (.clk(clk), .rst_b(rst_b), .axi_req(req),
    .axi_rsp(rsp), .int_status(st_l), .int_lines(int_l), .chan_busy(busy),
    .chan_wide(wide), .chan_data(cdata), .chan_sel(csel), .chan_strobe(strb),
    .chan_clear(clr), .rtc_hold(rtc));
  cxs_periph i_per (.clk(clk), .rst_b(rst_b), .chan_data(cdata), .chan_strobe(strb),
    .chan_clear(clr), .hold_busy(hold), .chan_busy(busy), .chan_wide(wide), .last_word(lastw));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rtc === 1'b1) rtc_seen <= 1'b1;
    if (clr !== 8'h00) clr_seen <= clr;
    if (cycles == 20000) begin
      errors = errors + 1;
      conclude();
    end
  end
  task conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bready and rready stay high, so every answer is taken at once
  // address and data channels are released each on its own ready
  task wr(input logic [5:0] idx, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    req.awaddr <= {idx, 2'b00};
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready === 1'b1) aw_ok = 1'b1;
      if (rsp.wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) req.awvalid <= 1'b0;
      if (w_ok) req.wvalid <= 1'b0;
    end while (!(aw_ok && w_ok));
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
  endtask : wr
  task rdr(input logic [5:0] idx);
    req.araddr <= {idx, 2'b00};
    req.arvalid <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
  endtask : rdr
  task ck(input logic [5:0] idx, input logic [31:0] exp);
    rdr(idx);
    chk(rd, exp);
  endtask : ck
  task ex(input logic [5:0] op, input logic [2:0] v, input logic [1:0] d, input logic [23:0] y);
    wr(R_PC, 32'h100);
    wr(R_OPND, {8'h00, y});
    wr(R_INSTR, {21'h0, d, v, op});
    do rdr(R_STATUS); while (rd[0] !== 1'b0);
  endtask : ex
  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    req.wstrb = 4'hF;
    {st_l, int_l, hold, rst_b, rtc_seen, clr_seen} = '0;
    {errors, comparisons, cycles} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    ck(R_ACC, 32'h0);
    wr(R_AUX, 32'h5);
    ex(OP_INC, 3'h0, 2'h0, 24'h3);
    ck(R_AUX, 32'h8);
    ck(R_PC, 32'h101);
    ex(OP_SKEQ, 3'h1, 2'h0, 24'h8);
    ck(R_PC, 32'h102);
    wr(R_IDX1, 32'h9);
    ex(OP_SKEQ, 3'h0, 2'h1, 24'h9);
    ck(R_PC, 32'h102);
    ex(OP_SKEQ, 3'h0, 2'h0, 24'h0);
    ck(R_PC, 32'h102);
    ex(OP_SKGE, 3'h0, 2'h1, 24'h3);
    ck(R_PC, 32'h102);
    ex(OP_SKGE, 3'h0, 2'h1, 24'hA);
    ck(R_PC, 32'h101);
    wr(R_IDX2, 32'h4);
    ex(OP_STEP, 3'h0, 2'h2, 24'h2);
    ck(R_IDX2, 32'h3);
    ex(OP_STEP, 3'h0, 2'h2, 24'h3);
    ck(R_IDX2, 32'h0);
    ck(R_PC, 32'h102);
    $display("test skip done");
    st_l <= 12'h010;
    int_l <= 12'h004;
    // state 5, condition high, interrupt mask bit 2
    wr(R_MODE, 32'h445);
    ex(OP_EXT, X_STSN, 2'h0, 24'h010);
    ck(R_PC, 32'h101);
    ex(OP_EXT, X_STSN, 2'h0, 24'h001);
    ck(R_PC, 32'h102);
    ex(OP_EXT, X_IRSN, 2'h0, 24'h0);
    ck(R_PC, 32'h101);
    int_l <= 12'h000;
    ex(OP_EXT, X_IRSN, 2'h0, 24'h0);
    ck(R_PC, 32'h102);
    wr(R_ACC, 32'hFFFFFF);
    ex(OP_EXT, X_ISTA, 2'h0, 24'h0);
    ck(R_ACC, 32'h5);
    ex(OP_DECJ, 3'h0, 2'h0, 24'h234);
    ck(R_PC, 32'h234);
    ex(OP_EXT, X_LJA, 2'h0, 24'h0);
    ck(R_ACC, 32'h234);
    $display("test sense done");
    wr(R_CHR0 + 6'h2, 32'h2A);
    ex(OP_LCHA, 3'h0, 2'h0, 24'h2);
    ck(R_ACC, 32'h2A);
    wr(R_ACC, 32'h3);
    wr(R_MEMW, 32'h5);
    ex(OP_MUL, 3'h0, 2'h0, 24'h0);
    ck(R_ACC, 32'hF);
    wr(R_ACC, 32'h123456);
    ex(OP_OUTC, 3'h0, 2'h0, 24'h0);
    chk({8'h00, lastw}, 32'h16);
    ck(R_ACC, 32'h123456);
    ex(OP_OUTW, 3'h0, 2'h0, 24'h0);
    chk({8'h00, lastw}, 32'h123456);
    ex(OP_OUTW, 3'h0, 2'h0, 24'h4);
    chk({8'h00, lastw}, 32'h456);
    chk({29'h0, csel}, 32'h4);
    ex(OP_EXT, X_CLR, 2'h0, 24'h100);
    chk({24'h0, clr_seen}, 32'hFF);
    $display("test data done");
    wr(R_ACC, 32'h12);
    wr(R_AUX, 32'hFF);
    wr(R_MEMW, 32'h312);
    wr(R_IDX1, 32'h5);
    ex(OP_SREQ, 3'h0, 2'h0, 24'h1);
    ck(R_PC, 32'h102);
    ck(R_IDX1, 32'h4);
    wr(R_ACC, 32'h11);
    wr(R_IDX2, 32'h2);
    ex(OP_SRGE, 3'h0, 2'h0, 24'h1);
    ck(R_PC, 32'h101);
    ck(R_IDX2, 32'h7FFF);
    ex(OP_MOVE, 3'h0, 2'h0, 24'h152);
    ck(R_CHR0 + 6'h5, 32'h2A);
    ex(OP_FMOVE, V_BF, 2'h0, 24'h3182);
    ck(R_CHR0 + 6'h8, 32'h2A);
    ck(R_CHR0 + 6'h9, {26'h0, CH_BLANK});
    ex(OP_FMOVE, V_ZS, 2'h0, 24'h33C0);
    ck(R_CHR0 + 6'hC, {26'h0, CH_BLANK});
    ck(R_CHR0 + 6'hE, 32'h2A);
    $display("test search move done");
    hold <= 8'h01;
    ex(OP_EXT, X_PRIW, 2'h0, 24'h1);
    ck(R_PC, 32'h101);
    chk({31'h0, rtc_seen}, 32'h1);
    hold <= 8'h00;
    ex(OP_EXT, X_WAIT, 2'h0, 24'h1);
    ck(R_PC, 32'h102);
    rdr(6'h0C);
    chk({30'h0, rr}, {30'h0, RESP_ERR});
    $display("test pause done");
    conclude();
  end
endmodule : testbench
